// ==== port_io_pin_control.sv ====
// Port pin control: latches, output modes, global control, special signals
// Assumes one processor access per cycle on core_clk; pads resolve drive outside
//
// What this block does
// - Each port 0 pin has a mode bit: 0 open-drain, 1 push-pull.
// - Port 2 has six pins, bits 5..0, same mode encoding.
// - Open-drain: low driver on for latch 0, never drive high.
// - Push-pull: exactly one driver on, following the latch.
// - Weak pullup only when not disabled, open-drain, latch 1.
// - Global pullup-disable bit 7 turns every weak pullup off.
// - Global input enable bit 6 gates all pin input paths.
// - Port data reads give 0 while inputs disabled, else pin levels.
// - Port data writes store into the pin latches.
// - Read-modify-write operations read latches, not pins.
// - Port data registers take byte and single-bit access.
// - Global bit 0 drives the inverse of inverted_system_clock_out_div_level onto port 0 pin 0.
// - Port 0 pin 3 feeds the external clock input through the input gate.
// - UART transmit on port 0 pin 4, receive from pin 5.
// - Port 0 pin 4 drives UART transmit ANDed with its latch.
// - Idle UART transmit rests high, so pin 4 follows its latch.
`include "port_io_consts.svh"
`default_nettype none
module port_io_pin_control
    import port_io_pkg::*;
#(
    parameter logic [7:0] P0_MASK = `PORT0_MASK,
    parameter logic [7:0] P2_MASK = `PORT2_MASK,
    parameter logic [7:0] P3_MASK = `PORT3_MASK
) (
    input  wire logic       core_clk,          // System clock, 250 MHz
    input  wire logic       rst_n,             // Synchronous reset, low
    input  wire sfr_req_t   sfr_req,           // Processor register access
    output logic [7:0]      sfr_rdata,         // Read data, registered
    input  wire logic       inverted_system_clock_out_div_level,  // System clock level for output
    input  wire logic       uart_tx,           // UART transmit, idle high
    output logic            uart_rx,           // UART receive to core
    output logic            external_clock_input,      // Pin 3 to clock logic
    output logic            external_interrupt0_input, // Pin-driven interrupt level
    input  wire logic [7:0] pad_in_p0,         // Port 0 pad levels
    input  wire logic [7:0] pad_in_p2,         // Port 2 pad levels
    input  wire logic [7:0] pad_in_p3,         // Port 3 pad levels
    output pad_drive_t      pad_p0,            // Port 0 pad drive
    output pad_drive_t      pad_p2,            // Port 2 pad drive
    output pad_drive_t      pad_p3,            // Port 3 pad drive
    output logic [7:0]      pin_in_p0,         // Gated synced port 0 input
    output logic [7:0]      pin_in_p2,         // Gated synced port 2 input
    output logic [7:0]      pin_in_p3          // Gated synced port 3 input
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] port0_data_latch_reg, port0_data_latch_next;
    logic [7:0] port2_data_latch_reg, port2_data_latch_next;
    logic [7:0] port3_data_latch_reg, port3_data_latch_next;
    logic [7:0] port0_output_mode_reg, port0_output_mode_next;
    logic [7:0] port2_output_mode_reg, port2_output_mode_next;
    logic [7:0] port3_output_mode_reg, port3_output_mode_next;
    logic [7:0] global_port_control_reg, global_port_control_next;
    logic [7:0] sfr_rdata_next;
    logic [7:0] sync_p0, sync_p2, sync_p3;

    // ----------------------------------------
    // Global control fields
    // ----------------------------------------
    wire logic weak_pullup_disable    = global_port_control_reg[`GCTL_PULLUP_DIS_BIT];
    wire logic global_input_enable    = global_port_control_reg[`GCTL_INPUT_EN_BIT];
    wire logic clock_output_route_bit = global_port_control_reg[`GCTL_CLKOUT_BIT];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic hit_p0d = sfr_req.addr == `ADDR_PORT0_DATA;
    wire logic hit_p2d = sfr_req.addr == `ADDR_PORT2_DATA;
    wire logic hit_p3d = sfr_req.addr == `ADDR_PORT3_DATA;
    wire logic hit_p0m = sfr_req.addr == `ADDR_PORT0_MODE;
    wire logic hit_p2m = sfr_req.addr == `ADDR_PORT2_MODE;
    wire logic hit_p3m = sfr_req.addr == `ADDR_PORT3_MODE;
    wire logic hit_gc  = sfr_req.addr == `ADDR_GLOBAL_CTRL;
    wire logic [7:0] bit_onehot = 8'h01 << sfr_req.bit_sel;

    // Merge a write into an old value, byte or single bit
    function automatic logic [7:0] merge_write(input logic [7:0] old_val,
                                               input logic [7:0] mask);
        logic [7:0] val;
        val = old_val;
        if (sfr_req.bit_op) begin
            val = sfr_req.wdata[0] ? (old_val | bit_onehot) : (old_val & ~bit_onehot);
        end else begin
            val = sfr_req.wdata;
        end
        return val & mask;
    endfunction : merge_write

    // ----------------------------------------
    // Next values of the writable registers
    // ----------------------------------------
    assign port0_data_latch_next = (sfr_req.wr && hit_p0d)
        ? (merge_write(port0_data_latch_reg, P0_MASK) | ~P0_MASK) : port0_data_latch_reg;
    assign port2_data_latch_next = (sfr_req.wr && hit_p2d)
        ? (merge_write(port2_data_latch_reg, P2_MASK) | ~P2_MASK) : port2_data_latch_reg;
    assign port3_data_latch_next = (sfr_req.wr && hit_p3d)
        ? (merge_write(port3_data_latch_reg, P3_MASK) | ~P3_MASK) : port3_data_latch_reg;
    assign port0_output_mode_next = (sfr_req.wr && hit_p0m)
        ? merge_write(port0_output_mode_reg, P0_MASK) : port0_output_mode_reg;
    assign port2_output_mode_next = (sfr_req.wr && hit_p2m)
        ? merge_write(port2_output_mode_reg, P2_MASK) : port2_output_mode_reg;
    assign port3_output_mode_next = (sfr_req.wr && hit_p3m)
        ? merge_write(port3_output_mode_reg, P3_MASK) : port3_output_mode_reg;
    assign global_port_control_next = (sfr_req.wr && hit_gc)
        ? merge_write(global_port_control_reg, `GCTL_WRITE_MASK) : global_port_control_reg;

    // Register update; reset leaves pins as undriven inputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port0_data_latch_reg    <= `LATCH_RESET;
            port2_data_latch_reg    <= `LATCH_RESET;
            port3_data_latch_reg    <= `LATCH_RESET;
            port0_output_mode_reg   <= `MODE_RESET;
            port2_output_mode_reg   <= `MODE_RESET;
            port3_output_mode_reg   <= `MODE_RESET;
            global_port_control_reg <= `GCTL_RESET;
            sfr_rdata               <= 8'h00;
        end else begin
            port0_data_latch_reg    <= port0_data_latch_next;
            port2_data_latch_reg    <= port2_data_latch_next;
            port3_data_latch_reg    <= port3_data_latch_next;
            port0_output_mode_reg   <= port0_output_mode_next;
            port2_output_mode_reg   <= port2_output_mode_next;
            port3_output_mode_reg   <= port3_output_mode_next;
            global_port_control_reg <= global_port_control_next;
            sfr_rdata               <= sfr_rdata_next;
        end
    end

    // ----------------------------------------
    // Input path
    // ----------------------------------------
    pin_sync #(.WIDTH(8)) u_sync_p0 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (pad_in_p0),
        .sync_out (sync_p0)
    );
    pin_sync #(.WIDTH(8)) u_sync_p2 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (pad_in_p2),
        .sync_out (sync_p2)
    );
    pin_sync #(.WIDTH(8)) u_sync_p3 (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (pad_in_p3),
        .sync_out (sync_p3)
    );

    // Input gate: disabled inputs read as 0
    assign pin_in_p0 = global_input_enable ? (sync_p0 & P0_MASK) : 8'h00;
    assign pin_in_p2 = global_input_enable ? (sync_p2 & P2_MASK) : 8'h00;
    assign pin_in_p3 = global_input_enable ? (sync_p3 & P3_MASK) : 8'h00;

    // Special inputs from port 0 through the gated path
    assign uart_rx                   = pin_in_p0[`P0_RX_PIN];
    assign external_clock_input      = pin_in_p0[`P0_EXTCLK_PIN];
    assign external_interrupt0_input = pin_in_p0[`P0_EXTCLK_PIN - 1];

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire logic [7:0] p0_view = sfr_req.rmw ? port0_data_latch_reg & P0_MASK : pin_in_p0;
    wire logic [7:0] p2_view = sfr_req.rmw ? port2_data_latch_reg & P2_MASK : pin_in_p2;
    wire logic [7:0] p3_view = sfr_req.rmw ? port3_data_latch_reg & P3_MASK : pin_in_p3;
    wire logic [7:0] sel_byte =
        hit_p0d ? p0_view :
        hit_p2d ? p2_view :
        hit_p3d ? p3_view :
        hit_p0m ? port0_output_mode_reg :
        hit_p2m ? port2_output_mode_reg :
        hit_p3m ? port3_output_mode_reg :
        hit_gc  ? global_port_control_reg : 8'h00;
    // Bit access returns the selected bit in bit 0
    assign sfr_rdata_next = !(sfr_req.rd || sfr_req.rmw) ? sfr_rdata :
        sfr_req.bit_op ? {7'h00, sel_byte[sfr_req.bit_sel]} : sel_byte;

    // ----------------------------------------
    // Output path
    // ----------------------------------------
    // Port 0 output value with special signals folded in
    logic [7:0] p0_level;
    always_comb begin
        p0_level = port0_data_latch_reg;
        p0_level[`P0_TX_PIN] = port0_data_latch_reg[`P0_TX_PIN] & uart_tx;
        if (clock_output_route_bit) begin
            p0_level[`P0_CLKOUT_PIN] = ~inverted_system_clock_out_div_level;
        end
    end

    pin_driver #(.PIN_MASK(P0_MASK)) u_drv_p0 (
        .out_level  (p0_level),
        .mode       (port0_output_mode_reg),
        .pullup_dis (weak_pullup_disable),
        .drive      (pad_p0)
    );
    pin_driver #(.PIN_MASK(P2_MASK)) u_drv_p2 (
        .out_level  (port2_data_latch_reg),
        .mode       (port2_output_mode_reg),
        .pullup_dis (weak_pullup_disable),
        .drive      (pad_p2)
    );
    pin_driver #(.PIN_MASK(P3_MASK)) u_drv_p3 (
        .out_level  (port3_data_latch_reg),
        .mode       (port3_output_mode_reg),
        .pullup_dis (weak_pullup_disable),
        .drive      (pad_p3)
    );
endmodule : port_io_pin_control
`default_nettype wire

// ==== port_io_consts.svh ====
// Offsets, field positions and reset values of the port block
// Assumes inclusion by bare name from the module files; the package does not include it
`ifndef PORT_IO_CONSTS_SVH
`define PORT_IO_CONSTS_SVH
// ----------------------------------------
// Register addresses (special-function space)
// ----------------------------------------
`define ADDR_PORT0_DATA    8'h80
`define ADDR_PORT0_MODE    8'hA4
`define ADDR_PORT2_DATA    8'hA0
`define ADDR_PORT2_MODE    8'hA6
`define ADDR_PORT3_DATA    8'hB0
`define ADDR_PORT3_MODE    8'hA7
`define ADDR_GLOBAL_CTRL   8'hE2
// ----------------------------------------
// Global control fields and resets
// ----------------------------------------
`define GCTL_PULLUP_DIS_BIT 7
`define GCTL_INPUT_EN_BIT   6
`define GCTL_CLKOUT_BIT     0
`define GCTL_RESET          8'h40
`define GCTL_WRITE_MASK     8'hC1
`define LATCH_RESET         8'hFF
`define MODE_RESET          8'h00
// ----------------------------------------
// Implemented pin masks per port
// ----------------------------------------
`define PORT0_MASK          8'hFF
`define PORT2_MASK          8'h3F
`define PORT3_MASK          8'h01
// Pin positions of the fixed special signals on port 0
`define P0_CLKOUT_PIN       0
`define P0_EXTCLK_PIN       3
`define P0_TX_PIN           4
`define P0_RX_PIN           5
`endif

// ==== port_io_pkg.sv ====
// Types shared by the port block files
// Assumes port_io_consts.svh is on the include path
`default_nettype none
package port_io_pkg;
    // One processor access to the special-function space
    typedef struct packed {
        logic       wr;        // Byte or bit write
        logic       rd;        // Byte or bit read of pins
        logic       rmw;       // Read of latch for modify-write
        logic       bit_op;    // Bit access instead of byte
        logic [2:0] bit_sel;   // Bit number for bit access
        logic [7:0] addr;      // Register address
        logic [7:0] wdata;     // Byte data, or bit value in [0]
    } sfr_req_t;
    // Pad drive for one port
    typedef struct packed {
        logic [7:0] out_val;   // Level driven when enabled
        logic [7:0] out_en;    // Driver enabled
        logic [7:0] pullup_en; // Weak pullup enabled
    } pad_drive_t;
    typedef enum logic [1:0] {
        PORT0_SEL,
        PORT2_SEL,
        PORT3_SEL
    } port_sel_t;
endpackage : port_io_pkg
`default_nettype wire

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bundle of pad inputs
// Assumes pad levels are asynchronous to core_clk
`include "port_io_consts.svh"
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk, // System clock
    input  wire logic             rst_n,    // Synchronous reset, low
    input  wire logic [WIDTH-1:0] async_in, // Raw pad levels
    output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;
    // Two flops; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ==== pin_driver.sv ====
// Drive decode for one port of pins
// Assumes latch and mode come from registers on core_clk
`include "port_io_consts.svh"
`default_nettype none
module pin_driver
    import port_io_pkg::*;
#(
    parameter logic [7:0] PIN_MASK = 8'hFF
) (
    input  wire logic [7:0] out_level,   // Effective output value
    input  wire logic [7:0] mode,        // 1 push-pull, 0 open-drain
    input  wire logic       pullup_dis,  // Global weak pullup disable
    output wire pad_drive_t drive        // Pad controls
);
    // Per-pin driver and pullup decode
    for (genvar i = 0; i < 8; i++) begin : g_pin
        wire logic low_on  = PIN_MASK[i] & ~out_level[i];
        wire logic high_on = PIN_MASK[i] & mode[i] & out_level[i];
        assign drive.out_en[i]    = low_on | high_on;
        assign drive.out_val[i]   = high_on;
        assign drive.pullup_en[i] = PIN_MASK[i] & ~pullup_dis & ~mode[i] & out_level[i];
    end
endmodule : pin_driver
`default_nettype wire

// ==== port_io_chk.sv ====
// Checker: timing relations at the port block's ports
// Assumes binding onto port_io_pin_control, one clock domain
`include "port_io_consts.svh"
`default_nettype none
module port_io_chk
    import port_io_pkg::*;
#(
    parameter logic [7:0] P2_MASK = `PORT2_MASK
) (
    input wire logic       core_clk,             // System clock
    input wire logic       rst_n,                // Reset, low
    input wire sfr_req_t   sfr_req,              // Register access
    input wire logic [7:0] sfr_rdata,            // Read data
    input wire logic       inverted_system_clock_out_div_level,     // Clock level
    input wire logic       uart_tx,              // UART transmit
    input wire logic       uart_rx,              // UART receive
    input wire logic       external_clock_input, // Clock input
    input wire pad_drive_t pad_p0,               // Port 0 drive
    input wire pad_drive_t pad_p2,               // Port 2 drive
    input wire logic [7:0] pin_in_p0,            // Port 0 input
    input wire logic [7:0] pin_in_p2             // Port 2 input
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Byte access decodes
    wire logic p2_wr = sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == `ADDR_PORT2_DATA;
    wire logic p2_rd = sfr_req.rd && !sfr_req.bit_op && sfr_req.addr == `ADDR_PORT2_DATA;
    wire logic g_wr  = sfr_req.wr && !sfr_req.bit_op && sfr_req.addr == `ADDR_GLOBAL_CTRL;
    AST_RST: assert property ($rose(rst_n) |-> pad_p2.out_en == 8'h00 && pad_p2.pullup_en == P2_MASK)
        else $error("reset drive wrong");
    AST_PU_DRIVEN: assert property (((pad_p0.pullup_en & pad_p0.out_en) | (pad_p2.pullup_en & pad_p2.out_en)) == 0)
        else $error("pullup on a driven pin");
    AST_P2_UNUSED: assert property (((pad_p2.out_en | pad_p2.pullup_en) & ~P2_MASK) == 8'h00)
        else $error("unused port 2 pin active");
    AST_WR_LOW: assert property (p2_wr |=> (pad_p2.out_en & ~pad_p2.out_val & P2_MASK) == (~$past(sfr_req.wdata) & P2_MASK))
        else $error("low drivers do not follow written latch");
    AST_PU_OFF: assert property (g_wr && sfr_req.wdata[7] |=> (pad_p0.pullup_en | pad_p2.pullup_en) == 8'h00)
        else $error("pullup left on");
    AST_IN_OFF: assert property (g_wr && !sfr_req.wdata[6] |=> (pin_in_p0 | pin_in_p2) == 8'h00)
        else $error("input path open");
    AST_RD_PINS: assert property (p2_rd |=> sfr_rdata == $past(pin_in_p2))
        else $error("read data not pin levels");
    AST_CLKOUT: assert property (g_wr && sfr_req.wdata[0] && !$past(pad_p0.out_en[0] & pad_p0.out_val[0])
        |=> (pad_p0.out_en[0] && !pad_p0.out_val[0]) == inverted_system_clock_out_div_level
            || (pad_p0.out_en[0] && pad_p0.out_val[0]) == !inverted_system_clock_out_div_level)
        else $error("clock output wrong");
    AST_EXTCLK: assert property (external_clock_input == pin_in_p0[3])
        else $error("clock input not from pin 3");
    AST_RX: assert property (uart_rx == pin_in_p0[5])
        else $error("receive not from pin 5");
    AST_TX_LOW: assert property (!uart_tx |-> pad_p0.out_en[4] && !pad_p0.out_val[4])
        else $error("transmit low not driven");
    COV_WR: cover property (p2_wr);
    COV_IN_OFF: cover property (g_wr && !sfr_req.wdata[6]);
    COV_TX: cover property (!uart_tx);
endmodule : port_io_chk
bind port_io_pin_control port_io_chk #(.P2_MASK(P2_MASK)) i_chk (.core_clk, .rst_n, .sfr_req, .sfr_rdata,
    .inverted_system_clock_out_div_level, .uart_tx, .uart_rx, .external_clock_input, .pad_p0, .pad_p2, .pin_in_p0, .pin_in_p2);
`default_nettype wire

// ==== pad_net.sv ====
// Pin network model: device drivers, outside drivers, pullups
// Assumes one instance per port, fed by the block's pad drive
`default_nettype none
module pad_net
    import port_io_pkg::*;
(
    input  wire logic       core_clk, // Clock for floating pattern
    input  wire pad_drive_t drive,    // Device pad controls
    input  wire logic [7:0] ext_en,   // Outside driver on
    input  wire logic [7:0] ext_val,  // Outside driver level
    output logic      [7:0] level     // Resolved pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wander = 8'h5A;
    // Undriven pins without pullup wander each cycle
    always @(posedge core_clk) wander <= ~wander;
    // Device driver wins, then outside driver, then pullup
    assign level = (drive.out_en & drive.out_val)
                 | (~drive.out_en & ext_en & ext_val)
                 | (~drive.out_en & ~ext_en & (drive.pullup_en | wander));
endmodule : pad_net
`default_nettype wire

// ==== test_port_io_pin_control.sv ====
// Testbench: port block against pin network model
// Assumes 250 MHz clock and the bound checker
`default_nettype none
module test_port_io_pin_control
    import port_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       core_clk = 1'b0, rst_n = 1'b0, inverted_system_clock_out_div_level = 1'b0, uart_tx = 1'b1, rd_prev = 1'b0;
    sfr_req_t   sfr_req = '0;
    logic [7:0] sfr_rdata, pad_in_p0, pad_in_p2, pad_in_p3, pin_in_p0, pin_in_p2, pin_in_p3;
    logic       uart_rx, external_clock_input, external_interrupt0_input;
    pad_drive_t pad_p0, pad_p2, pad_p3;
    logic [7:0] ext_en0 = '0, ext_val0 = '0, ext_en2 = '0, m, d, x, v;
    logic [7:0] exp_q[$];
    int         err_total = 0, comparisons = 0, cycles = 0, seed_v;
    port_io_pin_control i_dut (.core_clk, .rst_n, .sfr_req, .sfr_rdata, .inverted_system_clock_out_div_level, .uart_tx, .uart_rx,
        .external_clock_input, .external_interrupt0_input, .pad_in_p0, .pad_in_p2, .pad_in_p3, .pad_p0, .pad_p2,
        .pad_p3, .pin_in_p0, .pin_in_p2, .pin_in_p3);
    pad_net i_pn0 (.core_clk, .drive(pad_p0), .ext_en(ext_en0), .ext_val(ext_val0), .level(pad_in_p0));
    pad_net i_pn2 (.core_clk, .drive(pad_p2), .ext_en(ext_en2), .ext_val(8'h00), .level(pad_in_p2));
    pad_net i_pn3 (.core_clk, .drive(pad_p3), .ext_en(8'h00), .ext_val(8'h00), .level(pad_in_p3));
    always #2 core_clk = ~core_clk;
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One access held for one taken edge
    task automatic acc(input logic w, r, k, b, input logic [2:0] s, input logic [7:0] a, dv);
        @(posedge core_clk);
        sfr_req <= '{w, r, k, b, s, a, dv};
        @(posedge core_clk);
        sfr_req <= '0;
        #1;
    endtask : acc
    task automatic wr(input logic [7:0] a, dv);
        acc(1'b1, 1'b0, 1'b0, 1'b0, 3'd0, a, dv);
    endtask : wr
    task automatic rd(input logic k, input logic [7:0] a, exp);
        exp_q.push_back(exp);
        acc(1'b0, !k, k, 1'b0, 3'd0, a, 8'h00);
    endtask : rd
    // Read results checked against the oldest note
    always @(posedge core_clk) begin
        rd_prev <= sfr_req.rd | sfr_req.rmw;
        if (rd_prev) chk("sfr_rdata", exp_q.pop_front(), sfr_rdata);
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            print_verdict();
        end
    end
    initial begin
        seed_v = $urandom(1);
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1 chk("p2 out_en", 8'h00, pad_p2.out_en);
        chk("p2 pullup", 8'h3F, pad_p2.pullup_en);
        rd(1'b0, 8'hE2, 8'h40);
        rd(1'b0, 8'hA6, 8'h00);
        rd(1'b1, 8'hA0, 8'h3F);
        rd(1'b0, 8'hA0, 8'h3F);
        rd(1'b0, 8'h55, 8'h00);
        for (int i = 0; i < 8; i++) begin
            m = 8'($urandom);
            d = 8'($urandom);
            x = 8'($urandom) & d & ~m & 8'h3F;
            wr(8'hA6, m);
            wr(8'hA0, d);
            chk("p2 out_en", (~d | m) & 8'h3F, pad_p2.out_en);
            chk("p2 out_val", d & (~d | m) & 8'h3F, pad_p2.out_val & (~d | m) & 8'h3F);
            chk("p2 pullup", ~m & d & 8'h3F, pad_p2.pullup_en);
            @(posedge core_clk) ext_en2 <= x;
            repeat (3) @(posedge core_clk);
            rd(1'b0, 8'hA0, d & ~x & 8'h3F);
            rd(1'b1, 8'hA0, d & 8'h3F);
        end
        @(posedge core_clk) ext_en2 <= 8'h00;
        wr(8'hA6, 8'h00);
        wr(8'hA0, 8'hFF);
        acc(1'b1, 1'b0, 1'b0, 1'b1, 3'd2, 8'hA0, 8'h00);
        chk("p2 bit", 8'h04, pad_p2.out_en);
        exp_q.push_back(8'h00);
        acc(1'b0, 1'b0, 1'b1, 1'b1, 3'd2, 8'hA0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr(8'h80, {3'b111, k[0], 4'hF});
            @(posedge core_clk) uart_tx <= k[1];
            #1 chk("p0 tx", {3'b000, !(k[0] && k[1]), 4'h0}, pad_p0.out_en & 8'h10);
        end
        @(posedge core_clk) uart_tx <= 1'b1;
        wr(8'hE2, 8'h41);
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk) inverted_system_clock_out_div_level <= k[0];
            #1 chk("clk out", {7'h00, k[0]}, {7'h00, pad_p0.out_en[0] & ~pad_p0.out_val[0]});
        end
        wr(8'hE2, 8'h40);
        chk("p0 pin0", 8'h01, pad_p0.pullup_en & 8'h01);
        v = 8'($urandom);
        @(posedge core_clk) ext_en0 <= 8'h2C;
        ext_val0 <= v;
        repeat (3) @(posedge core_clk);
        #1 chk("ext clk", {7'h00, v[3]}, {7'h00, external_clock_input});
        chk("uart rx", {7'h00, v[5]}, {7'h00, uart_rx});
        chk("external_interrupt0_input", {7'h00, v[2]}, {7'h00, external_interrupt0_input});
        wr(8'hE2, 8'hC0);
        chk("pullups", 8'h00, pad_p0.pullup_en | pad_p2.pullup_en);
        wr(8'hE2, 8'h80);
        repeat (3) @(posedge core_clk);
        #1 chk("p0 in", 8'h00, pin_in_p0);
        rd(1'b0, 8'hA0, 8'h00);
        rd(1'b0, 8'hE2, 8'h80);
        repeat (2) @(posedge core_clk);
        print_verdict();
    end
endmodule : test_port_io_pin_control
`default_nettype wire
